// >>> src/prs_consts.svh
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
// ==========================================================
// timing figures, as printed, and clock rate
`define PRS_CLK_HZ 10000000
`define PRS_SYS_DELAY_MS 10
`define PRS_CORE_DELAY_MS 125
`define PRS_RELEASE_DELAY_MS 125
`define PRS_EXT_OSC_DELAY_MS 3000
`define PRS_MS_TO_CYC(ms) ((ms) * (`PRS_CLK_HZ / 1000))
// timer width, enough for 3000 ms at 10 MHz (3e7 cycles)
`define PRS_TMR_W 32
`endif

// >>> src/prs_pkg.sv
package prs_pkg;
  typedef enum logic [2:0] {
    PRS_OFF = 3'b000,
    PRS_WAIT_REL = 3'b001,
    PRS_SYS_DLY = 3'b010,
    PRS_CORE_DLY = 3'b011,
    PRS_REL_DLY = 3'b100,
    PRS_HOLD_FAULT = 3'b101,
    PRS_RUN = 3'b110
  } prs_state_t;
  // pins driven by the sequencer
  typedef struct packed {
    logic batteryPowerOut;
    logic systemSupplyEnable;
    logic coreSupplyEnable;
    logic resetIndicatorOutN;
  } prs_pins_t;
endpackage

// >>> src/prs_delay_timer.sv
`timescale 1ns/1ps
`include "prs_consts.svh"
// ==========================================================
// delay timer: load a count, raise expired when it runs out and hold it
module prs_delay_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [`PRS_TMR_W-1:0] loadVal,
  // status
  output logic expired
);
  logic [`PRS_TMR_W-1:0] count_r;
  logic running_r;

  // count down; expired holds once reached, until the next load
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_r <= '0;
      running_r <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      count_r <= loadVal;
      running_r <= 1'b1;
      expired <= 1'b0;
    end else if (running_r) begin
      if (count_r <= `PRS_TMR_W'(1)) begin
        running_r <= 1'b0;
        expired <= 1'b1;
      end else begin
        count_r <= count_r - `PRS_TMR_W'(1);
      end
    end
  end
endmodule

// >>> src/prs_sequencer.sv
`timescale 1ns/1ps
`include "prs_consts.svh"
// Operation
// R1: battery supply detected starts power-on reset
// R2: full reset state, only at first power
// R3: controller holds hard reset 10 ms after battery
// R4: assert battery power out and reset indicator
// R5: battery fault low blocks sequencing start
// R6: system enable 10 ms after release, indicator 0
// R7: I/O rail first, all within 125 ms
// R8: core enable 125 ms after system enable
// R9: core rails up within 125 ms
// R10: supply fault released within 120 ms
// R11: sample supply fault after both timers expire
// R12: release indicator 125 ms after core enable
// R13: external oscillator waits 3000 ms instead
// R14: supply fault still low keeps reset held
module prs_sequencer #(
  // figures in clk_sys cycles; a bench may pass much smaller ones
  // to keep runs short, the order of events stays the same
  parameter int unsigned SYS_DLY_CYC = `PRS_MS_TO_CYC(`PRS_SYS_DELAY_MS),
  parameter int unsigned CORE_DLY_CYC = `PRS_MS_TO_CYC(`PRS_CORE_DELAY_MS),
  parameter int unsigned REL_DLY_CYC = `PRS_MS_TO_CYC(`PRS_RELEASE_DELAY_MS),
  parameter int unsigned EXT_OSC_DLY_CYC = `PRS_MS_TO_CYC(`PRS_EXT_OSC_DELAY_MS)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // inputs from the power-control subsystem
  input wire logic backup_battery_supply,
  input wire logic hard_reset_in_n,
  input wire logic main_battery_fault_n,
  input wire logic supply_fault_n,
  input wire logic clock_request_indicator,
  // supply and reset outputs
  output logic battery_power_out,
  output logic system_supply_enable,
  output logic core_supply_enable,
  output logic reset_indicator_out_n,
  // status
  output prs_pkg::prs_state_t seqState,
  output logic runMode
);
  prs_pkg::prs_state_t state_r;
  prs_pkg::prs_state_t state_nxt;
  prs_pkg::prs_pins_t pins_r;
  prs_pkg::prs_pins_t pins_nxt;
  logic poweredOnce_r;
  logic sysLoad;
  logic coreLoad;
  logic [`PRS_TMR_W-1:0] sysVal;
  logic sysExpired;
  logic coreExpired;
  logic coreTmrDone_r;
  logic startOk;
  logic faultSampleOk;
  logic hardResetLost;
  logic batteryGone;

  // ==========================================================
  // delay timers
  // both count clk_sys cycles; expired stands until reloaded
  // system delay: short figure, or the long settle of an outside oscillator
  prs_delay_timer uSysTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(sysLoad),
    .loadVal(sysVal),
    .expired(sysExpired)
  );

  // one timer serves both the core enable delay and the release delay
  // trade-off: a second counter saved, at the cost of coreTmrDone_r
  prs_delay_timer uCoreTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(coreLoad),
    .loadVal(state_r == prs_pkg::PRS_SYS_DLY ? `PRS_TMR_W'(CORE_DLY_CYC)
                                              : `PRS_TMR_W'(REL_DLY_CYC)),
    .expired(coreExpired)
  );

  // external oscillator needs a much longer settle
  assign sysVal = clock_request_indicator ? `PRS_TMR_W'(EXT_OSC_DLY_CYC) // R13
                                          : `PRS_TMR_W'(SYS_DLY_CYC); // R6

  // ==========================================================
  // conditions the sequence waits on
  // the sequence starts once hard reset is released and the battery flag is good, in either order
  assign startOk = hard_reset_in_n && main_battery_fault_n; // R5

  // rail flag counts only once both delays have run out; sysExpired
  // stands from its expiry until sysLoad at the next start of the sequence
  assign faultSampleOk = sysExpired && coreTmrDone_r && coreExpired; // R11

  // hard reset pulled after the wait is handled like a fresh one
  assign hardResetLost = !hard_reset_in_n && state_r != prs_pkg::PRS_OFF
                         && state_r != prs_pkg::PRS_WAIT_REL;

  // losing the battery is the only way back to fully unpowered
  assign batteryGone = !backup_battery_supply; // R1

  // ==========================================================
  // sequence control
  always_comb begin
    // defaults: hold state and pins, no timer loads
    state_nxt = state_r;
    pins_nxt = pins_r;
    sysLoad = 1'b0;
    coreLoad = 1'b0;
    unique case (state_r)
      prs_pkg::PRS_OFF: begin
        pins_nxt = '{default: 1'b0};
        // only the first battery detect after being unpowered counts
        if (backup_battery_supply && !poweredOnce_r) begin // R1 R2
          pins_nxt.batteryPowerOut = 1'b1; // R4
          pins_nxt.resetIndicatorOutN = 1'b0; // R4
          state_nxt = prs_pkg::PRS_WAIT_REL;
        end
      end
      prs_pkg::PRS_WAIT_REL: begin
        // controller holds hard reset low long enough (R3)
        if (startOk) begin // R5
          sysLoad = 1'b1; // R6
          state_nxt = prs_pkg::PRS_SYS_DLY;
        end
      end
      prs_pkg::PRS_SYS_DLY: begin
        if (sysExpired) begin
          pins_nxt.systemSupplyEnable = 1'b1; // R6
          coreLoad = 1'b1; // R8
          state_nxt = prs_pkg::PRS_CORE_DLY;
        end
      end
      prs_pkg::PRS_CORE_DLY: begin
        if (coreExpired) begin
          pins_nxt.coreSupplyEnable = 1'b1; // R8
          coreLoad = 1'b1; // R12
          state_nxt = prs_pkg::PRS_REL_DLY;
        end
      end
      prs_pkg::PRS_REL_DLY, prs_pkg::PRS_HOLD_FAULT: begin
        // supply fault ignored until both timers have run out
        if (faultSampleOk) begin // R11
          if (supply_fault_n) begin
            pins_nxt.resetIndicatorOutN = 1'b1; // R12
            state_nxt = prs_pkg::PRS_RUN;
          end else begin
            state_nxt = prs_pkg::PRS_HOLD_FAULT; // R14
          end
        end
      end
      prs_pkg::PRS_RUN: begin
        // left only through hard reset or battery loss
        state_nxt = prs_pkg::PRS_RUN;
      end
      default: begin
        state_nxt = prs_pkg::PRS_OFF;
        pins_nxt = '{default: 1'b0};
      end
    endcase
    // losing hard reset after the wait, run included, restarts the wait; supplies drop
    if (hardResetLost) begin
      state_nxt = prs_pkg::PRS_WAIT_REL;
      pins_nxt.systemSupplyEnable = 1'b0;
      pins_nxt.coreSupplyEnable = 1'b0;
      pins_nxt.resetIndicatorOutN = 1'b0;
    end
    // battery gone: back to fully unpowered
    if (batteryGone) begin // R1
      state_nxt = prs_pkg::PRS_OFF;
      pins_nxt = '{default: 1'b0};
    end
  end

  // ==========================================================
  // registers
  // state register; sync reset parks every supply off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= prs_pkg::PRS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // output pins, reset indicator asserted from reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins_r <= '{batteryPowerOut: 1'b0, systemSupplyEnable: 1'b0,
                  coreSupplyEnable: 1'b0, resetIndicatorOutN: 1'b0};
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // the core timer's first expiry marks the core delay as done
  // cleared at every restart so a stale expiry is never taken
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == prs_pkg::PRS_WAIT_REL) begin
      coreTmrDone_r <= 1'b0;
    end else if (state_r == prs_pkg::PRS_CORE_DLY && coreExpired) begin
      coreTmrDone_r <= 1'b1; // R11
    end
  end

  // power-on reset happens once per battery application
  // limitation: a dip that never drops the battery flag cannot
  // start a second power-on reset, only a hard reset
  always_ff @(posedge clk_sys) begin
    if (rst || !backup_battery_supply) begin
      poweredOnce_r <= 1'b0;
    end else if (state_r == prs_pkg::PRS_WAIT_REL) begin
      poweredOnce_r <= 1'b1; // R2
    end
  end

  // ==========================================================
  // outputs
  assign battery_power_out = pins_r.batteryPowerOut;
  assign system_supply_enable = pins_r.systemSupplyEnable;
  assign core_supply_enable = pins_r.coreSupplyEnable;
  assign reset_indicator_out_n = pins_r.resetIndicatorOutN;
  assign seqState = state_r;
  assign runMode = (state_r == prs_pkg::PRS_RUN);
endmodule

// >>> testbench/prs_sequencer_chk.sv
`timescale 1ns/1ps
// ==========================================================
// pin ordering checks on the sequencer
module prs_sequencer_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // inputs from the power-control side
  input wire logic backup_battery_supply,
  input wire logic hard_reset_in_n,
  input wire logic main_battery_fault_n,
  input wire logic supply_fault_n,
  input wire logic clock_request_indicator,
  // outputs
  input wire logic battery_power_out,
  input wire logic system_supply_enable,
  input wire logic core_supply_enable,
  input wire logic reset_indicator_out_n,
  input wire logic runMode,
  input wire prs_pkg::prs_state_t seqState
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_start_pins: assert property (
    $rose(backup_battery_supply) |=> battery_power_out && !reset_indicator_out_n
  ) else $error("start pins wrong");
  chk_battery_off: assert property (
    !backup_battery_supply |=> !battery_power_out && !system_supply_enable && !core_supply_enable
  ) else $error("outputs live without battery");
  chk_batt_fault_block: assert property (
    seqState == prs_pkg::PRS_WAIT_REL && !main_battery_fault_n && backup_battery_supply
    |=> seqState == prs_pkg::PRS_WAIT_REL
  ) else $error("left wait with battery fault");
  chk_sys_order: assert property (
    $rose(system_supply_enable) |-> hard_reset_in_n && !core_supply_enable
  ) else $error("system enable out of order");
  chk_core_order: assert property (
    $rose(core_supply_enable) |-> system_supply_enable && !reset_indicator_out_n
  ) else $error("core enable out of order");
  // release needs core on for a while and a good rail flag
  chk_release_sample: assert property (
    $rose(reset_indicator_out_n)
    |-> $past(core_supply_enable, 8) && $past(supply_fault_n)
  ) else $error("release without timers or rails");
  chk_fault_hold: assert property (
    seqState == prs_pkg::PRS_HOLD_FAULT |-> !reset_indicator_out_n && !runMode
  ) else $error("released while rails bad");
  chk_run_pins: assert property (
    runMode |-> reset_indicator_out_n && core_supply_enable && system_supply_enable
  ) else $error("run without full power");
  // release only out of the states that wait on both timers
  chk_release_state: assert property (
    $rose(reset_indicator_out_n) |-> $past(seqState) == prs_pkg::PRS_REL_DLY
      || $past(seqState) == prs_pkg::PRS_HOLD_FAULT
  ) else $error("release from wrong state");
  chk_hard_reset_drop: assert property (
    backup_battery_supply && !hard_reset_in_n && seqState != prs_pkg::PRS_OFF
      && seqState != prs_pkg::PRS_WAIT_REL
    |=> seqState == prs_pkg::PRS_WAIT_REL && !system_supply_enable && !core_supply_enable
  ) else $error("hard reset left supplies on");
endmodule
bind prs_sequencer prs_sequencer_chk u_chk (.*);

// >>> testbench/prs_partner.sv
`timescale 1ns/1ps
// ==========================================================
// power-control subsystem facing the sequencer
module prs_partner #(
  // stands for the 10 ms minimum hold at the bench's scale
  parameter int HOLD_CYC = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bench commands
  input wire logic backup_battery_supply,
  input wire logic stuck,
  input wire logic bfHold,
  input wire logic hrHold,
  input wire logic [7:0] railDly,
  // seen from the sequencer
  input wire logic core_supply_enable,
  // driven to the sequencer
  output logic hard_reset_in_n,
  output logic main_battery_fault_n,
  output logic supply_fault_n
);
  int battCnt;
  int coreCnt;
  // ages of battery and core enable
  always_ff @(posedge clk_sys) begin
    battCnt <= (rst || !backup_battery_supply) ? 0 : battCnt + 1;
    coreCnt <= (rst || !core_supply_enable) ? 0 : coreCnt + 1;
  end
  // fault flag goes high one cycle ahead of hard reset; bfHold breaks that
  assign main_battery_fault_n = battCnt >= HOLD_CYC && !bfHold;
  // hrHold pulls hard reset again in mid-sequence
  assign hard_reset_in_n = battCnt > HOLD_CYC && !hrHold;
  // rails good railDly after core enable, unless told to stick
  assign supply_fault_n = !stuck && coreCnt > railDly;
endmodule

// >>> testbench/prs_sequencer_test.sv
`timescale 1ns/1ps
// ==========================================================
// power-on sequencer bench
module prs_sequencer_test;
  localparam int SYS = 20, CORE = 40, REL = 40, EXT = 60;
  logic clk_sys = 0, rst = 1, backup_battery_supply = 0, clock_request_indicator = 0;
  logic stuck = 0, bfHold = 0, hrHold = 0, hard_reset_in_n, main_battery_fault_n;
  logic supply_fault_n;
  logic battery_power_out, system_supply_enable, core_supply_enable;
  logic reset_indicator_out_n, runMode;
  logic [7:0] railDly = 8'h05;
  prs_pkg::prs_state_t seqState;
  int err_count = 0, n_compared = 0, cyc = 0, t0, e;
  int expQ[$];
  always #50 clk_sys = ~clk_sys;
  prs_sequencer #(.SYS_DLY_CYC(SYS), .CORE_DLY_CYC(CORE), .REL_DLY_CYC(REL),
    .EXT_OSC_DLY_CYC(EXT)) dut (.*);
  prs_partner #(.HOLD_CYC(SYS)) far (.*);
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // delays may run a few cycles over the timer figure, never under
  function automatic int win(int d, int x);
    return (d >= x && d <= x + 4) ? x : d;
  endfunction
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // cycle count and hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      complete_run;
    end
  end
  // power-ups: plain, external oscillator, stuck rails, late battery flag,
  // hard reset pulled mid-sequence
  initial begin
    void'($urandom(32'h10d26f33));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      railDly <= 8'($urandom_range(1, 30));
      clock_request_indicator <= (i == 1);
      stuck <= (i == 2);
      bfHold <= (i == 3);
      backup_battery_supply <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check({battery_power_out, reset_indicator_out_n}, 2'b10);
      while (!hard_reset_in_n) @(negedge clk_sys);
      if (bfHold) begin
        repeat (SYS + 10) @(negedge clk_sys);
        check({system_supply_enable, seqState}, {1'b0, prs_pkg::PRS_WAIT_REL});
        @(posedge clk_sys);
        bfHold <= 1'b0;
        @(negedge clk_sys);
      end
      // model: the delays the rules give, in the order they fall due
      expQ = {(i == 1) ? EXT : SYS, CORE, REL};
      t0 = cyc;
      e = expQ.pop_front();
      while (!system_supply_enable) @(negedge clk_sys);
      check(win(cyc - t0, e), e);
      if (i == 4) begin
        // hard reset pulled: supplies drop and the wait starts over
        @(posedge clk_sys);
        hrHold <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check({system_supply_enable, seqState}, {1'b0, prs_pkg::PRS_WAIT_REL});
        @(posedge clk_sys);
        hrHold <= 1'b0;
        @(negedge clk_sys);
        t0 = cyc;
        while (!system_supply_enable) @(negedge clk_sys);
        check(win(cyc - t0, SYS), SYS);
      end
      t0 = cyc;
      e = expQ.pop_front();
      while (!core_supply_enable) @(negedge clk_sys);
      check(win(cyc - t0, e), e);
      t0 = cyc;
      e = expQ.pop_front();
      if (stuck) begin
        repeat (REL + 10) @(negedge clk_sys);
        check({reset_indicator_out_n, seqState}, {1'b0, prs_pkg::PRS_HOLD_FAULT});
        @(posedge clk_sys);
        stuck <= 1'b0;
        @(negedge clk_sys);
        t0 = cyc - REL;
      end
      while (!reset_indicator_out_n) @(negedge clk_sys);
      check(win(cyc - t0, e), e);
      check(runMode, 1'b1);
      @(posedge clk_sys);
      backup_battery_supply <= 1'b0;
      repeat (2) @(negedge clk_sys);
      check({battery_power_out, system_supply_enable, core_supply_enable}, 3'h0);
    end
    complete_run;
  end
endmodule
